/* pinmx_top.sv */
// Strap sampling, activity LED and configuration pin logic of the PHY
//
// What this block does
// [RQ1] During reset the transmit LED pin is an input giving address bit 3.
// [RQ2] During reset the receive LED pin is an input giving address bit 4.
// [RQ3] A low strap gives address bit zero, a high strap gives one.
// [RQ4] After reset the transmit LED pin is driven, high while transmitting.
// [RQ5] After reset the receive LED pin is driven, high while receiving.
// [RQ6] Speed and auto-negotiation pins are inputs in hardware mode, outputs otherwise.
// [RQ7] Hardware mode: speed pin low selects 10 Mb/s, high selects 100 Mb/s.
// [RQ8] Software mode: speed pin shows low for 10 Mb/s, high for 100 Mb/s.
// [RQ9] Hardware mode: auto-negotiation pin high enables it, low disables it.
// [RQ10] Software mode: auto-negotiation pin shows high when enabled, low when not.
// [RQ11] Crossover enable input, pulled up on the board side so it defaults on.
// [RQ12] Mode select low means hardware mode, high means software mode.
// [RQ13] Address straps are latched at reset release and held until next reset.
`timescale 1ns/1ns
`default_nettype none
module pinmx_top (
  // Clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           rst_n,
  // Register port
  input  wire logic [pinmx_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [pinmx_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [pinmx_pkg::DATA_W-1:0]   reg_rdata,
  // Address 3 strap and transmit LED pin
  input  wire logic                           addr3_tx_led_pin_lvl,
  output logic                                addr3_tx_led_pin_drv,
  output logic                                addr3_tx_led_pin_en_n,
  // Address 4 strap and receive LED pin
  input  wire logic                           addr4_rx_led_pin_lvl,
  output logic                                addr4_rx_led_pin_drv,
  output logic                                addr4_rx_led_pin_en_n,
  // Speed select pin
  input  wire logic                           speed_select_pin_lvl,
  output logic                                speed_select_pin_drv,
  output logic                                speed_select_pin_en_n,
  // Auto-negotiation select pin
  input  wire logic                           autoneg_select_pin_lvl,
  output logic                                autoneg_select_pin_drv,
  output logic                                autoneg_select_pin_en_n,
  // Plain configuration inputs
  input  wire logic                           config_source_select,
  input  wire logic                           auto_crossover_enable,
  // Activity from the PHY core
  input  wire logic                           tx_activity,
  input  wire logic                           rx_activity,
  // Resulting configuration toward the core
  output logic      [1:0]                     phy_addr_hi,
  output logic                                speed_100,
  output logic                                autoneg_en,
  output logic                                mdix_en
);

  // Register decode shared by read and write paths
  function automatic logic reg_hit(
    input logic [pinmx_pkg::ADDR_W-1:0] addr,
    input logic [pinmx_pkg::ADDR_W-1:0] ofs
  );
    return addr == ofs;
  endfunction : reg_hit

  // Start-up sequence
  pinmx_pkg::pinmx_state_t state_q;
  pinmx_pkg::pinmx_state_t state_d;

  // Sampled mode and inputs
  logic mode_q;
  logic mdix_q;
  logic tx_led_q;
  logic rx_led_q;
  logic tx_led_d;
  logic rx_led_d;

  // Software control and status
  pinmx_pkg::pinmx_ctrl_t ctrl_q;
  pinmx_pkg::pinmx_ctrl_t ctrl_d;
  pinmx_pkg::pinmx_stat_t stat;
  logic [pinmx_pkg::DATA_W-1:0] rdata_d;

  // Decode
  logic wr_ctrl;
  logic rd_ctrl;
  logic rd_stat;

  // Strap control
  logic       strap_capture;
  logic       leds_live;
  logic [1:0] strap_lvl;

  // Configuration pin cells
  logic [pinmx_pkg::CFG_PINS-1:0] cfg_lvl;
  logic [pinmx_pkg::CFG_PINS-1:0] cfg_sw;
  logic [pinmx_pkg::CFG_PINS-1:0] cfg_drv;
  logic [pinmx_pkg::CFG_PINS-1:0] cfg_en_n;
  logic [pinmx_pkg::CFG_PINS-1:0] cfg_val;
  logic                           sw_mode;

  // Start-up sequence: first edge after release samples the straps,
  // so the LED pins are never driven while they may still carry strap levels
  always_comb begin
    state_d = state_q;
    case (state_q)
      pinmx_pkg::ST_HOLD:  state_d = pinmx_pkg::ST_LATCH;
      pinmx_pkg::ST_LATCH: state_d = pinmx_pkg::ST_RUN;
      pinmx_pkg::ST_RUN:   state_d = pinmx_pkg::ST_RUN;
      default:             state_d = pinmx_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pinmx_pkg::ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  assign strap_capture = state_q == pinmx_pkg::ST_HOLD; // [RQ1] [RQ2]
  assign leds_live     = state_q == pinmx_pkg::ST_RUN;
  assign strap_lvl     = {addr4_rx_led_pin_lvl, addr3_tx_led_pin_lvl}; // [RQ1] [RQ2]

  pinmx_strap_latch u_strap (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .capture   (strap_capture),
    .strap_lvl (strap_lvl),
    .addr_hi_q (phy_addr_hi)
  );

  // LED pins: inputs until the straps are taken, then activity outputs
  assign tx_led_d = leds_live ? tx_activity : pinmx_pkg::LED_OFF; // [RQ4]
  assign rx_led_d = leds_live ? rx_activity : pinmx_pkg::LED_OFF; // [RQ5]

  assign addr3_tx_led_pin_drv  = tx_led_q; // [RQ4]
  assign addr4_rx_led_pin_drv  = rx_led_q; // [RQ5]
  assign addr3_tx_led_pin_en_n = leds_live ? pinmx_pkg::OE_DRIVE : pinmx_pkg::OE_FLOAT; // [RQ1]
  assign addr4_rx_led_pin_en_n = leds_live ? pinmx_pkg::OE_DRIVE : pinmx_pkg::OE_FLOAT; // [RQ2]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_led_q <= pinmx_pkg::LED_OFF;
      rx_led_q <= pinmx_pkg::LED_OFF;
    end else begin
      tx_led_q <= tx_led_d;
      rx_led_q <= rx_led_d;
    end
  end

  // Mode and crossover inputs; pull-up lives at the pad, not here
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= pinmx_pkg::MODE_HW;
      mdix_q <= pinmx_pkg::MDIX_RST;
    end else begin
      mode_q <= config_source_select; // [RQ12]
      mdix_q <= auto_crossover_enable; // [RQ11]
    end
  end

  assign sw_mode = mode_q == pinmx_pkg::MODE_SW; // [RQ12]
  assign mdix_en = mdix_q; // [RQ11]

  // Configuration pin cells, one per mode-dependent pin
  assign cfg_lvl[pinmx_pkg::CFG_SPEED] = speed_select_pin_lvl;
  assign cfg_lvl[pinmx_pkg::CFG_ANEG]  = autoneg_select_pin_lvl;
  assign cfg_sw[pinmx_pkg::CFG_SPEED]  = ctrl_q.speed_100;
  assign cfg_sw[pinmx_pkg::CFG_ANEG]   = ctrl_q.aneg_en;

  generate
    for (genvar g = 0; g < pinmx_pkg::CFG_PINS; g++) begin : g_cfg
      pinmx_cfg_pin #(
        .RST_VAL (pinmx_pkg::CFG_RST[g])
      ) u_pin (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .sw_mode  (sw_mode), // [RQ6]
        .sw_value (cfg_sw[g]),
        .pin_lvl  (cfg_lvl[g]),
        .pin_drv  (cfg_drv[g]),
        .pin_en_n (cfg_en_n[g]),
        .value_q  (cfg_val[g])
      );
    end
  endgenerate

  assign speed_select_pin_drv    = cfg_drv[pinmx_pkg::CFG_SPEED]; // [RQ8]
  assign speed_select_pin_en_n   = cfg_en_n[pinmx_pkg::CFG_SPEED]; // [RQ6]
  assign autoneg_select_pin_drv  = cfg_drv[pinmx_pkg::CFG_ANEG]; // [RQ10]
  assign autoneg_select_pin_en_n = cfg_en_n[pinmx_pkg::CFG_ANEG]; // [RQ6]
  assign speed_100               = cfg_val[pinmx_pkg::CFG_SPEED]; // [RQ7]
  assign autoneg_en              = cfg_val[pinmx_pkg::CFG_ANEG]; // [RQ9]

  // Register port
  assign wr_ctrl = reg_wr && reg_hit(reg_addr, pinmx_pkg::CTRL_OFS);
  assign rd_ctrl = reg_rd && reg_hit(reg_addr, pinmx_pkg::CTRL_OFS);
  assign rd_stat = reg_rd && reg_hit(reg_addr, pinmx_pkg::STAT_OFS);

  // Control bits only take effect in software mode; kept in hardware mode too
  assign ctrl_d = wr_ctrl ? pinmx_pkg::pinmx_ctrl_t'(reg_wdata[$bits(pinmx_pkg::pinmx_ctrl_t)-1:0])
                          : ctrl_q;

  assign stat = '{
    mdix_en:     mdix_q,
    aneg_en:     autoneg_en,
    speed_100:   speed_100,
    sw_mode:     sw_mode,
    phy_addr_hi: phy_addr_hi
  };

  // Unmapped reads and idle cycles give zero
  assign rdata_d = rd_ctrl ? pinmx_pkg::DATA_W'(ctrl_q)
                 : rd_stat ? pinmx_pkg::DATA_W'(stat)
                 : '0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q    <= pinmx_pkg::CTRL_RST;
      reg_rdata <= '0;
    end else begin
      ctrl_q    <= ctrl_d;
      reg_rdata <= rdata_d;
    end
  end

  // Checks
  sequence s_boot;
    state_q == pinmx_pkg::ST_HOLD ##1 state_q == pinmx_pkg::ST_LATCH;
  endsequence

  sequence s_tx_on;
    leds_live && tx_activity;
  endsequence

  sequence s_rx_on;
    leds_live && rx_activity;
  endsequence

  sequence s_tx_idle;
    leds_live && !tx_activity;
  endsequence

  a_boot_order: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ4]
    s_boot |=> leds_live && addr3_tx_led_pin_en_n == pinmx_pkg::OE_DRIVE)
    else $error("LED pins not driven after strap sampling");

  a_strap_float: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ1]
    !leds_live |-> addr3_tx_led_pin_en_n == pinmx_pkg::OE_FLOAT
                && addr4_rx_led_pin_en_n == pinmx_pkg::OE_FLOAT)
    else $error("strap pin driven before sampling");

  a_strap_sample: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ2]
    strap_capture |=> phy_addr_hi == $past(strap_lvl) ##1 $stable(phy_addr_hi))
    else $error("address straps not sampled at release");

  a_tx_led: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ4]
    s_tx_on |=> addr3_tx_led_pin_drv && !addr3_tx_led_pin_en_n)
    else $error("transmit LED not lit on activity");

  a_rx_led: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ5]
    leds_live |=> addr4_rx_led_pin_drv == $past(rx_activity))
    else $error("receive LED does not follow activity");

  a_pin_dir: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ6]
    speed_select_pin_en_n == autoneg_select_pin_en_n
    && (speed_select_pin_en_n == pinmx_pkg::OE_DRIVE) == sw_mode)
    else $error("configuration pin direction does not follow mode");

  a_mode_sel: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ12]
    config_source_select |=> sw_mode)
    else $error("high mode select did not give software mode");

  a_aneg_hw: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ9]
    !sw_mode |=> autoneg_en == $past(autoneg_select_pin_lvl))
    else $error("hardware auto-negotiation select not followed");

  a_aneg_sw: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ10]
    sw_mode && $stable(ctrl_q) |=> autoneg_select_pin_drv == $past(ctrl_q.aneg_en))
    else $error("auto-negotiation status pin wrong");

  a_mdix_in: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ11]
    ##1 mdix_en == $past(auto_crossover_enable))
    else $error("crossover enable not followed");

  a_rdata_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside the cycle after a read");

  a_led_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ2]
    !leds_live |-> addr3_tx_led_pin_drv == pinmx_pkg::LED_OFF
                && addr4_rx_led_pin_drv == pinmx_pkg::LED_OFF)
    else $error("LED pin shows activity before strap sampling");

  a_rx_on: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ5]
    s_rx_on |=> addr4_rx_led_pin_drv && addr4_rx_led_pin_en_n == pinmx_pkg::OE_DRIVE)
    else $error("receive LED not lit on activity");

  a_tx_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ4]
    s_tx_idle |=> addr3_tx_led_pin_drv == pinmx_pkg::LED_OFF)
    else $error("transmit LED lit without activity");

  a_rx_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ5]
    leds_live && !rx_activity |=> addr4_rx_led_pin_drv == pinmx_pkg::LED_OFF)
    else $error("receive LED lit without activity");

  a_led_drive: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ5]
    leds_live |-> addr3_tx_led_pin_en_n == pinmx_pkg::OE_DRIVE
               && addr4_rx_led_pin_en_n == pinmx_pkg::OE_DRIVE)
    else $error("LED pins not driven after reset");

  a_run_stays: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ4]
    leds_live |=> leds_live)
    else $error("LED drive dropped before next reset");

  a_speed_hw: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ7]
    !sw_mode |=> speed_100 == $past(speed_select_pin_lvl))
    else $error("hardware speed select not followed");

  a_speed_sw: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ8]
    sw_mode |=> speed_select_pin_drv == $past(ctrl_q.speed_100))
    else $error("speed status pin wrong");

  a_cfg_float: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ6]
    !sw_mode |-> speed_select_pin_en_n == pinmx_pkg::OE_FLOAT
              && autoneg_select_pin_en_n == pinmx_pkg::OE_FLOAT)
    else $error("configuration pin driven in hardware mode");

  a_mode_hw: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ12]
    !config_source_select |=> !sw_mode)
    else $error("low mode select did not give hardware mode");

  a_addr_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ13]
    leds_live |=> $stable(phy_addr_hi))
    else $error("address bits changed after sampling");

  a_addr_map: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ3]
    strap_capture |=> phy_addr_hi == {$past(addr4_rx_led_pin_lvl),
                                      $past(addr3_tx_led_pin_lvl)})
    else $error("address strap bits in wrong place");

  a_latch_once: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ13]
    strap_capture |=> !strap_capture)
    else $error("strap capture repeated");

  a_rdata_unmapped: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && !rd_ctrl && !rd_stat |=> reg_rdata == '0)
    else $error("unmapped read returned data");

endmodule : pinmx_top
`default_nettype wire

/* pinmx_pkg.sv */
// Shared constants and types for the strap and LED pin block
package pinmx_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;

  // Pin conventions
  localparam logic MODE_HW   = 1'b0;
  localparam logic MODE_SW   = 1'b1;
  localparam logic OE_DRIVE  = 1'b0;
  localparam logic OE_FLOAT  = 1'b1;
  localparam logic LED_OFF   = 1'b0;
  localparam logic MDIX_RST  = 1'b1;

  // Index of each configuration pin in the pin cell array
  localparam int CFG_SPEED = 0;
  localparam int CFG_ANEG  = 1;
  localparam int CFG_PINS  = 2;

  // Software control word
  typedef struct packed {
    logic aneg_en;
    logic speed_100;
  } pinmx_ctrl_t;

  localparam pinmx_ctrl_t CTRL_RST = '{aneg_en: 1'b1, speed_100: 1'b1};
  localparam logic [CFG_PINS-1:0] CFG_RST = {CTRL_RST.aneg_en, CTRL_RST.speed_100};

  // Status word
  typedef struct packed {
    logic       mdix_en;
    logic       aneg_en;
    logic       speed_100;
    logic       sw_mode;
    logic [1:0] phy_addr_hi;
  } pinmx_stat_t;

  localparam logic [1:0] ADDR_HI_RST = 2'h0;

  // Start-up sequence, Gray coded
  typedef enum logic [1:0] {
    ST_HOLD  = 2'h0,
    ST_LATCH = 2'h1,
    ST_RUN   = 2'h3
  } pinmx_state_t;
endpackage : pinmx_pkg

/* pinmx_strap_latch.sv */
// Address strap capture and hold
`timescale 1ns/1ns
`default_nettype none
module pinmx_strap_latch (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Capture control
  input  wire logic       capture,
  input  wire logic [1:0] strap_lvl,
  // Held address bits
  output logic      [1:0] addr_hi_q
);
  logic [1:0] addr_hi_d;

  // Low pin gives zero, high pin gives one
  assign addr_hi_d = capture ? strap_lvl : addr_hi_q; // [RQ3] [RQ13]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_hi_q <= pinmx_pkg::ADDR_HI_RST;
    end else begin
      addr_hi_q <= addr_hi_d;
    end
  end

  a_strap_take: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ3]
    capture |=> addr_hi_q == $past(strap_lvl))
    else $error("strap level not taken");

  a_strap_keep: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ13]
    !capture |=> $stable(addr_hi_q))
    else $error("strap value changed outside capture");
endmodule : pinmx_strap_latch
`default_nettype wire

/* pinmx_cfg_pin.sv */
// One mode-dependent configuration pin: input in hardware mode, status output in software mode
`timescale 1ns/1ns
`default_nettype none
module pinmx_cfg_pin #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Mode and software value
  input  wire logic sw_mode,
  input  wire logic sw_value,
  // Pin
  input  wire logic pin_lvl,
  output logic      pin_drv,
  output logic      pin_en_n,
  // Effective selection
  output logic      value_q
);
  logic value_d;

  assign value_d  = sw_mode ? sw_value : pin_lvl; // [RQ7] [RQ9]
  assign pin_drv  = value_q; // [RQ8] [RQ10]
  assign pin_en_n = sw_mode ? pinmx_pkg::OE_DRIVE : pinmx_pkg::OE_FLOAT; // [RQ6]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= RST_VAL;
    end else begin
      value_q <= value_d;
    end
  end

  a_cfg_hw_follow: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ7]
    !sw_mode |=> value_q == $past(pin_lvl))
    else $error("hardware mode value does not follow pin");

  a_cfg_sw_drive: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ8]
    sw_mode ##1 sw_mode |-> pin_en_n == pinmx_pkg::OE_DRIVE && pin_drv == $past(sw_value))
    else $error("software mode pin not driven with selection");
endmodule : pinmx_cfg_pin
`default_nettype wire

/* pinmx_board.sv */
// Board model: strap resistors on the pads and crossover pull-up
`timescale 1ns/1ns
`default_nettype none
module pinmx_board (
  // Strap resistors, index 0 addr3/tx, 1 addr4/rx, 2 speed, 3 autoneg
  input  wire logic [3:0] strap,
  // Optional board driver on the crossover input
  input  wire logic       xover_drv_en,
  input  wire logic       xover_val,
  // Pad drive from the device
  input  wire logic [3:0] pin_drv,
  input  wire logic [3:0] pin_en_n,
  // Resolved levels
  output logic      [3:0] pin_lvl,
  output logic            xover_lvl
);
  // Strong device drive wins over a strap; a floating pad shows its strap
  assign pin_lvl   = (pin_drv & ~pin_en_n) | (strap & pin_en_n);
  // Undriven input reads high through the pull-up
  assign xover_lvl = xover_drv_en ? xover_val : 1'b1;
endmodule : pinmx_board
`default_nettype wire

/* pinmx_top_bench.sv */
// Self-checking bench for the strap, LED and configuration pin block
`timescale 1ns/1ns
`default_nettype none
module pinmx_top_bench;
  typedef struct packed {
    logic [1:0]  sel;
    logic [31:0] exp;
  } pinmx_note_t;

  logic              ref_clk;
  logic              rst_n;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic [3:0]        strap;
  logic [3:0]        drv;
  logic [3:0]        en_n;
  logic [3:0]        lvl;
  logic              xover_drv_en;
  logic              xover_val;
  logic              xover_lvl;
  logic              cfg_sel;
  logic              tx_act;
  logic              rx_act;
  logic [1:0]        phy_addr_hi;
  logic              speed_100;
  logic              autoneg_en;
  logic              mdix_en;
  logic              probe;
  logic              mon_go;
  logic [1:0]        addr;
  logic [31:0]       rnd;
  pinmx_note_t       notes[$];
  int                num_errors;
  int                total_checks;

  pinmx_top pinmx_top_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .addr3_tx_led_pin_lvl(lvl[0]), .addr3_tx_led_pin_drv(drv[0]),
    .addr3_tx_led_pin_en_n(en_n[0]), .addr4_rx_led_pin_lvl(lvl[1]),
    .addr4_rx_led_pin_drv(drv[1]), .addr4_rx_led_pin_en_n(en_n[1]),
    .speed_select_pin_lvl(lvl[2]), .speed_select_pin_drv(drv[2]),
    .speed_select_pin_en_n(en_n[2]), .autoneg_select_pin_lvl(lvl[3]),
    .autoneg_select_pin_drv(drv[3]), .autoneg_select_pin_en_n(en_n[3]),
    .config_source_select(cfg_sel), .auto_crossover_enable(xover_lvl),
    .tx_activity(tx_act), .rx_activity(rx_act), .phy_addr_hi(phy_addr_hi),
    .speed_100(speed_100), .autoneg_en(autoneg_en), .mdix_en(mdix_en)
  );

  pinmx_board pinmx_board_inst (
    .strap(strap), .xover_drv_en(xover_drv_en), .xover_val(xover_val),
    .pin_drv(drv), .pin_en_n(en_n), .pin_lvl(lvl), .xover_lvl(xover_lvl)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Monitor: outputs are looked at one edge after the probe or read strobe
  always @(posedge ref_clk) mon_go <= reg_rd | probe;
  always @(negedge ref_clk) begin
    pinmx_note_t n;
    if (mon_go) begin
      chk("note queue", {31'h0, notes.size() == 0}, 32'h0);
      n = notes.pop_front();
      case (n.sel)
        2'h0: chk("reg_rdata", reg_rdata, n.exp);
        2'h1: chk("led pins", {28'h0, drv[1], en_n[1], drv[0], en_n[0]}, n.exp);
        2'h2: chk("cfg pins", {28'h0, lvl[3], lvl[2], en_n[3], en_n[2]}, n.exp);
        default: chk("core cfg", {27'h0, mdix_en, autoneg_en, speed_100, phy_addr_hi},
                     n.exp);
      endcase
    end
  end

  // Probe spends two edges so the strobe never toggles twice in one step
  task automatic note(input logic [1:0] sel, input logic [31:0] exp);
    notes.push_back('{sel, exp});
    probe <= 1'b1;
    @(posedge ref_clk);
    probe <= 1'b0;
    @(posedge ref_clk);
  endtask : note

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    notes.push_back('{2'h0, exp});
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(posedge ref_clk);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  // Reset held over one rising edge; straps float-read while LED pads are inputs
  task automatic do_reset(input logic [3:0] s);
    strap   <= s;
    cfg_sel <= pinmx_pkg::MODE_HW;
    tx_act  <= 1'b0;
    rx_act  <= 1'b0;
    rst_n   <= 1'b0;
    addr = s[1:0];
    notes.push_back('{2'h1, 32'h5});
    probe <= 1'b1;
    @(posedge ref_clk);
    probe <= 1'b0;
    // Released off the edge so no check starts on an edge that still resets
    @(negedge ref_clk);
    rst_n <= 1'b1;
    note(2'h3, {27'h0, 1'b1, s[3], s[2], s[1:0]});
    note(2'h1, 32'h0);
  endtask : do_reset

  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    strap = 4'hF;
    xover_drv_en = 1'b0;
    xover_val = 1'b0;
    cfg_sel = 1'b0;
    tx_act = 1'b0;
    rx_act = 1'b0;
    probe = 1'b0;
    mon_go = 1'b0;
    num_errors = 0;
    total_checks = 0;
    void'($urandom(29549));
    @(posedge ref_clk);
    // Every address strap combination, each followed by LED traffic that must not disturb it
    for (int s = 0; s < 4; s++) begin
      do_reset({2'h3, s[1:0]});
      for (int k = 0; k < 8; k++) begin
        rnd = $urandom;
        tx_act <= rnd[0];
        rx_act <= rnd[1];
        note(2'h1, {28'h0, rnd[1], 1'b0, rnd[0], 1'b0});
      end
      note(2'h3, {27'h0, 1'b1, 1'b1, 1'b1, addr});
    end
    rd(pinmx_pkg::CTRL_OFS, 32'h3);
    // Hardware mode: pads are inputs, crossover pulled up or driven
    for (int i = 0; i < 4; i++) begin
      strap[3:2]   <= i[1:0];
      xover_drv_en <= i[0];
      xover_val    <= i[1];
      note(2'h3, {27'h0, ~i[0] | i[1], i[1], i[0], addr});
      note(2'h2, {28'h0, i[1:0], 2'h3});
    end
    xover_drv_en <= 1'b0;
    // Software mode: pads show the control word, strap levels ignored
    cfg_sel <= pinmx_pkg::MODE_SW;
    repeat (3) @(posedge ref_clk);
    for (int c = 0; c < 4; c++) begin
      rnd = $urandom;
      strap[3:2] <= ~c[1:0];
      wr(pinmx_pkg::CTRL_OFS, {rnd[31:2], c[1:0]});
      @(posedge ref_clk);
      note(2'h2, {28'h0, c[1:0], 2'h0});
      note(2'h3, {27'h0, 1'b1, c[1], c[0], addr});
      rd(pinmx_pkg::CTRL_OFS, {30'h0, c[1:0]});
      rd(pinmx_pkg::STAT_OFS, {26'h0, 1'b1, c[1], c[0], 1'b1, addr});
    end
    // Unmapped and read-only places
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h0);
    wr(pinmx_pkg::STAT_OFS, 32'h0);
    rd(pinmx_pkg::STAT_OFS, {26'h0, 1'b1, 2'h3, 1'b1, addr});
    // Reset in mid-run while in software mode and driving the pads
    tx_act <= 1'b1;
    rx_act <= 1'b0;
    note(2'h1, 32'h2);
    do_reset(4'h6);
    rd(pinmx_pkg::CTRL_OFS, 32'h3);
    repeat (3) @(posedge ref_clk);
    chk("queue drained", {31'h0, notes.size() == 0}, 32'h1);
    wrap_up();
  end

  // Watchdog against a hung sequence
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    wrap_up();
  end
endmodule : pinmx_top_bench
`default_nettype wire
